/* logic/rbm_pkg.sv */
// shared constants, types and coding functions of the burst modem codec
package rbm_pkg;
    // clock and line timing, each figure in its own unit
    localparam int CLK_MHZ = 200;
    localparam int BAUD = 1200;
    localparam int LONG_US = 500;
    localparam int SHORT_US = 250;
    localparam int WARM_US = 32000;
    localparam int BIT_CYC = CLK_MHZ * 1000000 / BAUD;
    localparam int LONG_CYC = LONG_US * CLK_MHZ;
    localparam int SHORT_CYC = SHORT_US * CLK_MHZ;
    localparam int WARM_CYC = WARM_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam int FIFO_DEPTH = 32;
    localparam int PKT_BYTES = 3;
    localparam int SYNC_LEN = 12;
    localparam int PKT_SYMS = 60;
    localparam int CHAR_BITS = 10;
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CNT = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // half-cycle patterns, a one is a long half-cycle, msb sent first
    localparam logic [11:0] SYNC_PAT = 12'h801;
    localparam logic [3:0] GRP_IDLE = 4'hf;
    localparam logic [3:0] GRP_C0 = 4'h3;
    localparam logic [3:0] GRP_C1 = 4'h5;
    localparam logic [3:0] GRP_C2 = 4'h9;
    localparam logic [3:0] GRP_C3 = 4'h6;
    // control register layout
    typedef struct packed {
        logic [6:0] chan;  // serially chosen channel
        logic enable;      // modem running
    } rbm_ctrl_t;
    localparam rbm_ctrl_t CTRL_RST = 8'h00;
    // bit pair to group code
    function automatic logic [3:0] grp_encode(input logic [1:0] pair);
        case (pair)
            2'h0: grp_encode = GRP_C0;
            2'h1: grp_encode = GRP_C1;
            2'h2: grp_encode = GRP_C2;
            default: grp_encode = GRP_C3;
        endcase
    endfunction
    // group code to {void, null, pair}
    function automatic logic [3:0] grp_decode(input logic [3:0] code);
        case (code)
            GRP_C0: grp_decode = 4'h0;
            GRP_C1: grp_decode = 4'h1;
            GRP_C2: grp_decode = 4'h2;
            GRP_C3: grp_decode = 4'h3;
            GRP_IDLE: grp_decode = 4'h4;
            default: grp_decode = 4'h8;
        endcase
    endfunction
endpackage

/* logic/rbm_modem_codec.sv */
// burst radio modem: host serial, fifos, packet coder and decoder, axi4-lite regs
//
// Contract
// - host serial 1200 baud, 8 data, 1 stop
// - one way only, no correction or retry
// - each end holds a 32 byte fifo
// - transmit fifo covers 32 ms transmitter warm-up
// - receive bytes leave at steady rate
// - key transmitter on when host data arrives
// - packet is sync plus three bytes
// - short packet fills missing bytes with idle
// - key off once transmit fifo empties
// - radio sees tone of coded half-cycles
// - long 500 us, short 250 us half-cycles
// - idle sends unbroken long half-cycles
// - sync is long, ten shorts, long
// - twelve four-symbol groups, two bits each
// - only four group codes carry data
// - void group discards whole packet
// - all-long group is null, not void
// - output only from bursts with sync
// - three active-low pins pick channel 0-7
// - open-collector squelch flag released without carrier
// - when enabled, use serially selected channel
// - transmit hold low forces continuous keying
`timescale 1ns/1ps
// plain synchronous byte fifo, writes while full are refused
module rbm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = rbm_pkg::FIFO_DEPTH,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [LW-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];  // storage words
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rptr];
    // pointers wrap since depth is a power of two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr <= '0;
            rptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                mem[wptr] <= in_data;
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            level <= level + LW'(push) - LW'(pop);
        end
    end
endmodule

module rbm_modem_codec #(
    parameter int BIT_CYC = rbm_pkg::BIT_CYC,
    parameter int LONG_CYC = rbm_pkg::LONG_CYC,
    parameter int SHORT_CYC = rbm_pkg::SHORT_CYC,
    parameter int WARM_CYC = rbm_pkg::WARM_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic host_txd,
    output logic host_rxd,
    input wire logic [2:0] channel_select_lines_n,
    input wire logic transmit_hold_n,
    output logic [6:0] channel,
    output logic tx_key,
    output logic tone_out,
    input wire logic tone_in,
    input wire logic carrier_present,
    output logic squelch_flag_out,
    output logic squelch_flag_oe_n
);
    localparam int CW = rbm_pkg::CNT_W;
    typedef enum logic [3:0] {
        TX_OFF = 4'b0001, TX_WARM = 4'b0010, TX_LOAD = 4'b0100, TX_SEND = 4'b1000
    } rbm_txs_t;
    typedef enum logic [2:0] {
        RX_HUNT = 3'b001, RX_DATA = 3'b010, RX_PUSH = 3'b100
    } rbm_rxs_t;
    rbm_pkg::rbm_ctrl_t ctrl;  // software control
    logic [7:0] drop_cnt;      // host bytes lost to a full fifo
    logic [7:0] rej_cnt;       // received packets rejected after sync: void group, out-of-range symbol or carrier loss
    // ---------------- axi4-lite slave ----------------
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [5:0] tx_lvl, rx_lvl;
    rbm_txs_t txs;
    wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
    wire wr_ctrl = do_wr && (aw_addr == rbm_pkg::ADDR_CTRL);
    wire wr_ok = (aw_addr == rbm_pkg::ADDR_CTRL) || (aw_addr == rbm_pkg::ADDR_STAT)
        || (aw_addr == rbm_pkg::ADDR_CNT);
    wire rd_ok = (s_axi_araddr == rbm_pkg::ADDR_CTRL) || (s_axi_araddr == rbm_pkg::ADDR_STAT)
        || (s_axi_araddr == rbm_pkg::ADDR_CNT);
    wire [31:0] stat_word = {18'h0_0000, !carrier_present, tx_key, rx_lvl[5:0], tx_lvl[5:0]};
    wire [31:0] rd_word = (s_axi_araddr == rbm_pkg::ADDR_CTRL) ? {24'h00_0000, ctrl} :
        (s_axi_araddr == rbm_pkg::ADDR_STAT) ? stat_word :
        (s_axi_araddr == rbm_pkg::ADDR_CNT) ? {16'h0000, rej_cnt, drop_cnt} : 32'h0000_0000;
    assign s_axi_awready = !aw_hold;
    assign s_axi_wready = !w_hold;
    assign s_axi_arready = !s_axi_rvalid;
    // address and data are latched apart, the answer follows both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rbm_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rbm_pkg::RESP_OKAY;
            ctrl <= rbm_pkg::CTRL_RST;
        end else begin
            if (s_axi_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? rbm_pkg::RESP_OKAY : rbm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // status and counter words ignore writes
            if (wr_ctrl && w_strb[0]) begin
                ctrl <= w_data[7:0];
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? rbm_pkg::RESP_OKAY : rbm_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // channel choice: serial setting once enabled, else the inverted pins
    assign channel = ctrl.enable ? ctrl.chan : {4'h0, ~channel_select_lines_n};
    // open collector: pull low while a carrier is heard, release under squelch
    assign squelch_flag_out = 1'b0;
    assign squelch_flag_oe_n = !carrier_present;
    // ---------------- host serial in, 10-bit frames ----------------
    logic [CW-1:0] hr_ctr;
    logic [3:0] hr_bit;
    logic hr_busy, hr_valid;
    logic [7:0] hr_sh;
    wire hr_tick = hr_busy && (hr_ctr == '0);
    // sample mid-bit; a start bit that is high again at mid-bit is a glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hr_busy <= 1'b0;
            hr_ctr <= '0;
            hr_bit <= 4'h0;
            hr_sh <= 8'h00;
            hr_valid <= 1'b0;
        end else begin
            hr_valid <= 1'b0;
            if (!hr_busy && !host_txd && ctrl.enable) begin
                hr_busy <= 1'b1;
                hr_ctr <= CW'(BIT_CYC / 2);
                hr_bit <= 4'h0;
            end else if (hr_busy) begin
                hr_ctr <= hr_tick ? CW'(BIT_CYC - 1) : hr_ctr - 1'b1;
            end
            if (hr_tick) begin
                hr_bit <= hr_bit + 1'b1;
                if (hr_bit == 4'h0 && host_txd) begin
                    hr_busy <= 1'b0;
                end else if (hr_bit == 4'(rbm_pkg::CHAR_BITS - 1)) begin
                    hr_busy <= 1'b0;
                    hr_valid <= host_txd;
                end else if (hr_bit != 4'h0) begin
                    hr_sh <= {host_txd, hr_sh[7:1]};
                end
            end
        end
    end
    // ---------------- transmit fifo and packet coder ----------------
    logic tf_ready, tf_valid, tf_pop;
    logic [7:0] tf_data;
    rbm_fifo u_txf (
        .aclk(aclk), .aresetn(aresetn),
        .in_valid(hr_valid), .in_ready(tf_ready), .in_data(hr_sh),
        .out_valid(tf_valid), .out_ready(tf_pop), .out_data(tf_data), .level(tx_lvl)
    );
    logic [CW-1:0] warm_ctr, hc_ctr;
    logic [5:0] pos;
    logic [1:0] ld_idx;
    logic [7:0] pk_byte [rbm_pkg::PKT_BYTES];
    logic [2:0] pk_val;
    wire hold = !transmit_hold_n;
    wire hc_end = (hc_ctr == '0);
    wire [5:0] d_idx = pos - 6'(rbm_pkg::SYNC_LEN);
    wire [7:0] d_byte = pk_byte[d_idx[5:4]];
    wire [1:0] d_pair = d_byte[{d_idx[3:2], 1'b0} +: 2];
    wire [3:0] d_code = pk_val[d_idx[5:4]] ? rbm_pkg::grp_encode(d_pair)
        : rbm_pkg::GRP_IDLE;
    wire pk_sym = (pos < 6'(rbm_pkg::SYNC_LEN)) ? rbm_pkg::SYNC_PAT[11 - pos]
        : d_code[2'd3 - d_idx[1:0]];
    // pos runs one past the last symbol so the edge that closes it is still sent
    wire pk_last = (pos == 6'(rbm_pkg::PKT_SYMS));
    wire sym_l = (txs == TX_SEND && !pk_last) ? pk_sym : 1'b1;
    assign tf_pop = (txs == TX_LOAD);
    // bytes wait in the fifo while the transmitter warms up on long tone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txs <= TX_OFF;
            tx_key <= 1'b0;
            tone_out <= 1'b0;
            warm_ctr <= '0;
            hc_ctr <= '0;
            pos <= 6'h00;
            ld_idx <= 2'h0;
            pk_val <= 3'h0;
            drop_cnt <= 8'h00;
        end else begin
            if (hr_valid && !tf_ready) begin
                drop_cnt <= drop_cnt + 1'b1;
            end
            if (txs != TX_OFF && hc_end) begin
                tone_out <= !tone_out;
                hc_ctr <= sym_l ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
            end else if (txs != TX_OFF) begin
                hc_ctr <= hc_ctr - 1'b1;
            end
            unique case (txs)
                TX_OFF: begin
                    if ((ctrl.enable && tf_valid) || hold) begin
                        txs <= TX_WARM;
                        tx_key <= 1'b1;
                        warm_ctr <= CW'(WARM_CYC - 1);
                        hc_ctr <= '0;
                    end
                end
                TX_WARM: begin
                    if (warm_ctr != '0) begin
                        warm_ctr <= warm_ctr - 1'b1;
                    end else if (tf_valid) begin
                        txs <= TX_LOAD;
                        ld_idx <= 2'h0;
                        pk_val <= 3'h0;
                    end else if (!hold) begin
                        txs <= TX_OFF;
                        tx_key <= 1'b0;
                    end
                end
                TX_LOAD: begin
                    pk_byte[ld_idx] <= tf_data;
                    pk_val[ld_idx] <= tf_valid;
                    ld_idx <= ld_idx + 1'b1;
                    if (ld_idx == 2'(rbm_pkg::PKT_BYTES - 1) || !tf_valid) begin
                        txs <= TX_SEND;
                        pos <= 6'h00;
                    end
                end
                TX_SEND: begin
                    if (hc_end && pk_last) begin
                        // keying off any sooner would cut the final half-cycle short
                        txs <= TX_WARM;
                        warm_ctr <= '0;
                    end else if (hc_end) begin
                        pos <= pos + 1'b1;
                    end
                end
            endcase
        end
    end
    // ---------------- packet decoder ----------------
    rbm_rxs_t rxs;
    logic tin_q;
    logic [CW-1:0] len;
    logic [11:0] sym_sr;
    logic [5:0] rcnt;
    logic [7:0] rb [rbm_pkg::PKT_BYTES];
    logic [2:0] rb_null;
    logic [1:0] px;
    logic rf_ready, rf_valid, rf_pop;
    logic [7:0] rf_data;
    wire t_edge = (tone_in != tin_q);
    wire s_ok = (len > CW'(SHORT_CYC / 2)) && (len < CW'(LONG_CYC + LONG_CYC / 2));
    wire s_l = (len > CW'((LONG_CYC + SHORT_CYC) / 2));
    wire [11:0] sr_next = {sym_sr[10:0], s_l};
    wire [3:0] g_dec = rbm_pkg::grp_decode(sr_next[3:0]);
    wire g_done = t_edge && s_ok && (rxs == RX_DATA) && (rcnt[1:0] == 2'h3);
    wire [5:0] r_idx = rcnt - 6'h03;
    wire rx_void = g_done && g_dec[3];
    wire rf_push = (rxs == RX_PUSH) && !rb_null[px];
    // symbols are timed between tone edges; out-of-range lengths are noise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxs <= RX_HUNT;
            tin_q <= 1'b0;
            len <= '0;
            sym_sr <= 12'h000;
            rcnt <= 6'h00;
            rb_null <= 3'h0;
            px <= 2'h0;
            rej_cnt <= 8'h00;
        end else begin
            tin_q <= tone_in;
            len <= t_edge ? CW'(1) : ((&len) ? len : len + 1'b1);
            if (t_edge) begin
                sym_sr <= sr_next;
            end
            unique case (rxs)
                RX_HUNT: begin
                    if (t_edge && s_ok && sr_next == rbm_pkg::SYNC_PAT && ctrl.enable) begin
                        rxs <= RX_DATA;
                        rcnt <= 6'h00;
                        rb_null <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (!carrier_present || (t_edge && !s_ok) || rx_void) begin
                        rxs <= RX_HUNT;
                        rej_cnt <= rej_cnt + 1'b1;
                    end else if (t_edge) begin
                        rcnt <= rcnt + 1'b1;
                        if (g_done) begin
                            rb[r_idx[5:4]][{r_idx[3:2], 1'b0} +: 2] <= g_dec[1:0];
                            if (g_dec[2]) begin
                                rb_null[r_idx[5:4]] <= 1'b1;
                            end
                        end
                        if (rcnt == 6'(rbm_pkg::PKT_SYMS - rbm_pkg::SYNC_LEN - 1)) begin
                            rxs <= RX_PUSH;
                            px <= 2'h0;
                        end
                    end
                end
                RX_PUSH: begin
                    px <= px + 1'b1;
                    if (px == 2'(rbm_pkg::PKT_BYTES - 1)) begin
                        rxs <= RX_HUNT;
                    end
                end
            endcase
        end
    end
    rbm_fifo u_rxf (
        .aclk(aclk), .aresetn(aresetn),
        .in_valid(rf_push), .in_ready(rf_ready), .in_data(rb[px]),
        .out_valid(rf_valid), .out_ready(rf_pop), .out_data(rf_data), .level(rx_lvl)
    );
    // ---------------- host serial out, paced one frame at a time ----------------
    logic [9:0] ht_sh;
    logic [3:0] ht_bit;
    logic [CW-1:0] ht_ctr;
    assign rf_pop = (ht_bit == 4'h0) && rf_valid;
    assign host_rxd = ht_sh[0];
    // stop bit always ends with idle high so frames never merge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ht_sh <= 10'h3ff;
            ht_bit <= 4'h0;
            ht_ctr <= '0;
        end else if (rf_pop) begin
            ht_sh <= {1'b1, rf_data, 1'b0};
            ht_bit <= 4'(rbm_pkg::CHAR_BITS);
            ht_ctr <= CW'(BIT_CYC - 1);
        end else if (ht_bit != 4'h0) begin
            ht_ctr <= (ht_ctr == '0) ? CW'(BIT_CYC - 1) : ht_ctr - 1'b1;
            if (ht_ctr == '0) begin
                ht_sh <= {1'b1, ht_sh[9:1]};
                ht_bit <= ht_bit - 1'b1;
            end
        end
    end
    // ---------------- checks ----------------
    sequence s_sync_start;
        (txs == TX_SEND) && hc_end && (pos == 6'h00);
    endsequence
    property p_full_drop;
        @(posedge aclk) disable iff (!aresetn)
        (hr_valid && !tf_ready && !tf_pop) |=> (tx_lvl == $past(tx_lvl));
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("byte into full fifo stored");
    property p_key_on;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl.enable && tf_valid && txs == TX_OFF) |=> tx_key;
    endproperty
    a_key_on: assert property (p_key_on)
        else $error("key not raised on data");
    property p_key_off;
        @(posedge aclk) disable iff (!aresetn)
        $fell(tx_key) |-> ($past(tx_lvl) == 6'h00) && $past(transmit_hold_n);
    endproperty
    a_key_off: assert property (p_key_off)
        else $error("key dropped with data or hold");
    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!transmit_hold_n) [*2] |-> tx_key;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold did not key transmitter");
    property p_half_len;
        @(posedge aclk) disable iff (!aresetn)
        (txs != TX_OFF && hc_end) |=>
            (hc_ctr == CW'(LONG_CYC - 1)) || (hc_ctr == CW'(SHORT_CYC - 1));
    endproperty
    a_half_len: assert property (p_half_len)
        else $error("half-cycle length wrong");
    property p_sync_shape;
        @(posedge aclk) disable iff (!aresetn)
        s_sync_start |=> (hc_ctr == CW'(LONG_CYC - 1));
    endproperty
    a_sync_shape: assert property (p_sync_shape)
        else $error("sync does not open long");
    property p_idle_long;
        @(posedge aclk) disable iff (!aresetn)
        (txs == TX_WARM && hc_end) |=> (hc_ctr == CW'(LONG_CYC - 1));
    endproperty
    a_idle_long: assert property (p_idle_long)
        else $error("idle tone not long");
    property p_void_drop;
        @(posedge aclk) disable iff (!aresetn)
        rx_void |=> !rf_push [*3];
    endproperty
    a_void_drop: assert property (p_void_drop)
        else $error("voided packet delivered");
    property p_squelch;
        @(posedge aclk) disable iff (!aresetn)
        squelch_flag_oe_n == !carrier_present;
    endproperty
    a_squelch: assert property (p_squelch)
        else $error("squelch flag wrong");
endmodule

/* sim/rbm_far_model.sv */
// far side model: a remote modem that hears our own radio output
`timescale 1ns/1ps
module rbm_far_model (
    input wire logic aclk,
    input wire logic tx_key,
    input wire logic tone_out,
    output logic tone_in,
    output logic carrier_present
);
    initial tone_in = 1'b0;
    // tone passes only while keyed; unkeyed air is noise that flips every cycle,
    // so a stale level never looks like a held half-cycle
    always @(posedge aclk) begin
        carrier_present <= tx_key;
        // an unknown key before reset must not poison the noise toggle for good
        tone_in <= (tx_key === 1'b1) ? tone_out : ~tone_in;
    end
endmodule

/* sim/rbm_modem_codec_test.sv */
// self-checking bench of the burst modem codec with a loopback radio path
`timescale 1ns/1ps
module rbm_modem_codec_test;
    localparam int BITC = 40;  // shortened serial bit time
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, host_txd, host_rxd, transmit_hold_n, tx_key, tone_out, tone_in;
    logic carrier_present, squelch_flag_out, squelch_flag_oe_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] channel_select_lines_n;
    logic [6:0] channel;
    logic [7:0] got[$];  // bytes seen on host_rxd
    int num_errors, checks, seed;
    rbm_modem_codec #(.BIT_CYC(BITC), .LONG_CYC(64), .SHORT_CYC(32), .WARM_CYC(100)) dut (.*);
    rbm_far_model far (.aclk(aclk), .tx_key(tx_key), .tone_out(tone_out), .tone_in(tone_in),
        .carrier_present(carrier_present));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic wrap_up;
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [6:0] exp_chan(input logic en, input logic [6:0] c, input logic [2:0] p);
        return en ? c : {4'h0, ~p};
    endfunction
    // one axi4-lite transfer; every change lands just after a rising edge
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            r = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (!done) begin
            num_errors++;
            wrap_up();
        end
    endtask
    // one 8n1 character, low bit first
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd <= f[i];
            repeat (BITC) @(posedge aclk);
        end
    endtask
    // host-side receiver, sampling each bit in its middle
    initial begin
        logic [7:0] rb;
        forever begin
            @(negedge host_rxd);
            repeat (BITC / 2) @(negedge aclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BITC) @(negedge aclk);
                rb[i] = host_rxd;
            end
            repeat (BITC) @(negedge aclk);
            got.push_back(rb);
        end
    end
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        logic [6:0] ch;
        logic [7:0] tx[$];
        int n;
        seed = 13147;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {host_txd, transmit_hold_n} = 2'h3;
        channel_select_lines_n = 3'($random(seed));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, 8'h00, 32'h0, q, r);
        chk("ctrl reset", 32'h0, q);
        chk("pin channel", exp_chan(1'b0, 7'h0, channel_select_lines_n), channel);
        axi(1'b0, 8'h0c, 32'h0, q, r);
        chk("unmapped resp", rbm_pkg::RESP_SLVERR, r);
        ch = 7'($random(seed));
        axi(1'b1, 8'h00, {24'h0, ch, 1'b1}, q, r);
        chk("ctrl resp", rbm_pkg::RESP_OKAY, r);
        chk("serial channel", exp_chan(1'b1, ch, channel_select_lines_n), channel);
        // one, two and three byte bursts: first byte alone in a padded packet, any rest together in one padded packet
        for (int k = 1; k <= 3; k++) begin
            got.delete();
            tx.delete();
            for (n = 0; n < k; n++) begin
                tx.push_back(8'($random(seed)));
                send(tx[n]);
            end
            @(negedge aclk);
            chk("key on", 32'h1, tx_key);
            for (n = 0; n < 20000 && got.size() < k; n++) @(negedge aclk);
            chk("rx count", k, got.size());
            if (got.size() < k) wrap_up();
            for (n = 0; n < k; n++) chk("rx byte", tx[n], got[n]);
            repeat (400) @(negedge aclk);
            chk("key off", 32'h0, tx_key);
            chk("squelch released", 32'h1, squelch_flag_oe_n);
        end
        got.delete();
        @(posedge aclk);
        transmit_hold_n <= 1'b0;
        repeat (300) @(negedge aclk);
        chk("hold key", 32'h1, tx_key);
        chk("carrier flag", 32'h0, squelch_flag_oe_n);
        chk("idle no output", 32'h0, got.size());
        // keyed by hold, carrier heard, both fifos drained
        axi(1'b0, 8'h04, 32'h0, q, r);
        chk("status word", 32'h0000_1000, q);
        // a clean loopback neither drops host bytes nor voids packets
        axi(1'b0, 8'h08, 32'h0, q, r);
        chk("drop and void counts", 32'h0, q);
        wrap_up();
    end
endmodule
